/* logic/eeprom_read_defs.svh */
// constants for the two-wire eeprom read path
`ifndef EEPROM_READ_DEFS_SVH
`define EEPROM_READ_DEFS_SVH
`define CTRL_CODE          4'hA
`define CTRL_CODE_MSB      7
`define CTRL_CODE_LSB      4
`define CTRL_SEL_MSB       3
`define CTRL_SEL_LSB       1
`define CTRL_DIR_BIT       0
`define DIR_READ           1'b1
`define DIR_WRITE          1'b0
`define ADDR_WIDTH         13
`define BYTE_BITS          8
`define PTR_RESET          13'h0000
`define CLK_PERIOD_NS      40
`define SCL_QUARTER_NS     625
`define SCL_QUARTER_CYCLES ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* logic/eeprom_read_pkg.sv */
// state and step types shared by both ends
package eeprom_read_pkg;
	typedef enum logic [2:0] {TGT_IDLE, TGT_RECV, TGT_ACK, TGT_SEND, TGT_MACK, TGT_WAIT} tgt_state_e;
	typedef enum logic [1:0] {RX_CTRL, RX_ADDR_HI, RX_ADDR_LO, RX_DATA} rx_kind_e;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_e;
	typedef enum logic [2:0] {S_CTRL_W, S_ADDR_HI, S_ADDR_LO, S_CTRL_R, S_READ} host_step_e;
endpackage

/* logic/two_wire_if.sv */
// open-drain two-wire bus joining controller and target
`timescale 1ns/1ps
interface two_wire_if;
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl_i;
	logic sda_i;

	// pulled-up wires: low whenever any enabled driver drives low
	assign scl_i = !(scl_oe && !scl_o);
	assign sda_i = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

	modport controller(output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl_i, sda_i);
	modport target(output sda_d_o, sda_d_oe, input scl_i, sda_i);
endinterface

/* logic/pin_sync.sv */
// two-flop synchroniser with edge pulses for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// raw pins
	input  wire logic [WIDTH-1:0] pin_in,
	// synchronised level and edges
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	// reset to the idle-high bus level so release gives no false edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
			prev_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// edges look only at the second and third stage
	assign level = sync_reg;
	assign rise  = sync_reg & ~prev_reg;
	assign fall  = ~sync_reg & prev_reg;
endmodule

/* logic/eeprom_target.sv */
// serial eeprom target: random and sequential read path
`timescale 1ns/1ps
`include "eeprom_read_defs.svh"

// Functional notes
// - controller loads address in a write transfer
// - controller sends repeated start after address
// - repeated start keeps pointer, no write cycle
// - controller resends control byte with read bit
// - matching read: acknowledge, send byte msb first
// - no ack then stop ends the read
// - after random read pointer is next location
// - controller ack fetches next sequential byte
// - controller ends stream with no ack, stop
// - pointer increments by one per byte
// - sequential read length is unlimited
// - pointer wraps from top to zero
// - respond only to code and chip select
// - control byte lsb selects read or write
// - two address bytes, high first, 13 bits
// - release data on missing ack for stop
module eeprom_target #(
	parameter int ADDR_W = `ADDR_WIDTH
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// two-wire bus
	two_wire_if.target             bus,
	// chip select straps
	input  wire logic              chip_select_bit_high,
	input  wire logic              chip_select_bit_mid,
	input  wire logic              chip_select_bit_low,
	// array preload
	input  wire logic              mem_load_en,
	input  wire logic [ADDR_W-1:0] mem_load_addr,
	input  wire logic [7:0]        mem_load_data,
	// status
	output logic      [ADDR_W-1:0] addr_pointer,
	output logic                   read_active
);
	localparam int HI_W = ADDR_W - `BYTE_BITS;

	logic [7:0]          mem [0:(1<<ADDR_W)-1];
	logic                scl_lvl;
	logic                scl_rise;
	logic                scl_fall;
	logic                sda_lvl;
	logic                sda_rise;
	logic                sda_fall;
	logic [2:0]          cs_lvl;
	logic                start_det;
	logic                stop_det;
	logic                byte_in;
	logic                load_byte;
	logic                addr_done;
	logic                ctrl_ok;
	eeprom_read_pkg::tgt_state_e state_reg;
	eeprom_read_pkg::rx_kind_e   kind_reg;
	logic [3:0]          bit_cnt_reg;
	logic [7:0]          shift_reg;
	logic [7:0]          tx_reg;
	logic [HI_W-1:0]     addr_hi_reg;
	logic [ADDR_W-1:0]   ptr_reg;
	logic                read_dir_reg;
	logic                ack_seen_reg;
	logic                sda_oe_reg;
	logic                active_reg;

	// control byte decode: fixed code and strapped select
	function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] sel);
		ctrl_match = (b[`CTRL_CODE_MSB:`CTRL_CODE_LSB] == `CTRL_CODE) &&
			(b[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == sel);
	endfunction

	// bus lines and straps all come from outside this clock
	pin_sync #(.WIDTH(2)) u_bus_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.pin_in  ({bus.scl_i, bus.sda_i}),
		.level   ({scl_lvl, sda_lvl}),
		.rise    ({scl_rise, sda_rise}),
		.fall    ({scl_fall, sda_fall})
	);

	pin_sync #(.WIDTH(3)) u_cs_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.pin_in  ({chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low}),
		.level   (cs_lvl),
		.rise    (),
		.fall    ()
	);

	// bus conditions: data edges while the clock is high
	assign start_det = sda_fall & scl_lvl;
	assign stop_det  = sda_rise & scl_lvl;

	// a full received byte is judged on the falling clock after bit eight
	assign byte_in   = (state_reg == eeprom_read_pkg::TGT_RECV) && scl_fall && (bit_cnt_reg == 4'h8);
	assign ctrl_ok   = ctrl_match(shift_reg, cs_lvl);
	assign addr_done = byte_in && (kind_reg == eeprom_read_pkg::RX_ADDR_LO);

	// fetch a byte after the read ack, or after each controller ack
	assign load_byte = scl_fall && !start_det && !stop_det &&
		(((state_reg == eeprom_read_pkg::TGT_ACK) && read_dir_reg) ||
		((state_reg == eeprom_read_pkg::TGT_MACK) && ack_seen_reg));

	// array preload port; the write path itself lives elsewhere
	always_ff @(posedge clk) begin
		if (mem_load_en) begin
			mem[mem_load_addr] <= mem_load_data;
		end
	end

	// address pointer: loaded by the address bytes, stepped per byte sent
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_reg     <= `PTR_RESET;
			addr_hi_reg <= '0;
		end else begin
			if (byte_in && (kind_reg == eeprom_read_pkg::RX_ADDR_HI)) begin
				addr_hi_reg <= shift_reg[HI_W-1:0];
			end
			if (addr_done) begin
				ptr_reg <= {addr_hi_reg, shift_reg};
			end else if (load_byte) begin
				ptr_reg <= ptr_reg + 1'b1;
			end
		end
	end

	// transmit shifter, msb on the wire first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_reg <= '0;
		end else if (load_byte) begin
			tx_reg <= mem[ptr_reg];
		end else if ((state_reg == eeprom_read_pkg::TGT_SEND) && scl_fall) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// bus state machine and data line driver
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= eeprom_read_pkg::TGT_IDLE;
			kind_reg     <= eeprom_read_pkg::RX_CTRL;
			bit_cnt_reg  <= '0;
			shift_reg    <= '0;
			read_dir_reg <= `DIR_WRITE;
			ack_seen_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else if (stop_det) begin
			state_reg  <= eeprom_read_pkg::TGT_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (start_det) begin
			// a repeated start simply reopens the control byte; no write is begun
			state_reg   <= eeprom_read_pkg::TGT_RECV;
			kind_reg    <= eeprom_read_pkg::RX_CTRL;
			bit_cnt_reg <= '0;
			sda_oe_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				eeprom_read_pkg::TGT_IDLE, eeprom_read_pkg::TGT_WAIT: begin
					sda_oe_reg <= 1'b0;
				end
				eeprom_read_pkg::TGT_RECV: begin
					if (scl_rise && (bit_cnt_reg != 4'h8)) begin
						shift_reg   <= {shift_reg[6:0], sda_lvl};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_in) begin
						state_reg  <= eeprom_read_pkg::TGT_ACK;
						sda_oe_reg <= 1'b1;
						unique case (kind_reg)
							eeprom_read_pkg::RX_CTRL: begin
								read_dir_reg <= shift_reg[`CTRL_DIR_BIT];
								kind_reg     <= eeprom_read_pkg::RX_ADDR_HI;
								if (!ctrl_ok) begin
									// not ours: stay silent until the next condition
									state_reg  <= eeprom_read_pkg::TGT_WAIT;
									sda_oe_reg <= 1'b0;
								end
							end
							eeprom_read_pkg::RX_ADDR_HI: kind_reg <= eeprom_read_pkg::RX_ADDR_LO;
							eeprom_read_pkg::RX_ADDR_LO: kind_reg <= eeprom_read_pkg::RX_DATA;
							eeprom_read_pkg::RX_DATA: begin
								// write data belongs to the write path; left unacknowledged
								state_reg  <= eeprom_read_pkg::TGT_WAIT;
								sda_oe_reg <= 1'b0;
							end
						endcase
					end
				end
				eeprom_read_pkg::TGT_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= '0;
						if (read_dir_reg) begin
							state_reg  <= eeprom_read_pkg::TGT_SEND;
							sda_oe_reg <= !mem[ptr_reg][7];
						end else begin
							state_reg  <= eeprom_read_pkg::TGT_RECV;
							sda_oe_reg <= 1'b0;
						end
					end
				end
				eeprom_read_pkg::TGT_SEND: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							state_reg  <= eeprom_read_pkg::TGT_MACK;
							sda_oe_reg <= 1'b0;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							sda_oe_reg  <= !tx_reg[6];
						end
					end
				end
				eeprom_read_pkg::TGT_MACK: begin
					if (scl_rise) begin
						ack_seen_reg <= !sda_lvl;
					end else if (scl_fall) begin
						bit_cnt_reg <= '0;
						if (ack_seen_reg) begin
							state_reg  <= eeprom_read_pkg::TGT_SEND;
							sda_oe_reg <= !mem[ptr_reg][7];
						end else begin
							// line stays released so the controller can make its stop
							state_reg  <= eeprom_read_pkg::TGT_WAIT;
							sda_oe_reg <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// status flag, one cycle behind the state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= (state_reg == eeprom_read_pkg::TGT_SEND) ||
				(state_reg == eeprom_read_pkg::TGT_MACK);
		end
	end

	// open drain: data value is always low, the enable does the work
	assign bus.sda_d_o  = 1'b0;
	assign bus.sda_d_oe = sda_oe_reg;
	assign addr_pointer = ptr_reg;
	assign read_active  = active_reg;
endmodule

/* logic/eeprom_controller.sv */
// two-wire controller issuing random and sequential reads
`timescale 1ns/1ps
`include "eeprom_read_defs.svh"
module eeprom_controller #(
	parameter int LEN_W = 14,
	parameter int QUARTER = `SCL_QUARTER_CYCLES
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// two-wire bus
	two_wire_if.controller        bus,
	// read command
	input  wire logic             cmd_start,
	input  wire logic [2:0]       cmd_dev_sel,
	input  wire logic [12:0]      cmd_addr,
	input  wire logic [LEN_W-1:0] cmd_len,
	// results
	output logic                  busy,
	output logic                  rd_valid,
	output logic      [7:0]       rd_data,
	output logic                  no_ack
);
	logic sda_lvl;
	logic tick;
	logic [7:0] div_reg;
	logic [1:0] q_reg;
	logic [3:0] bit_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [2:0] sel_reg;
	logic [12:0] addr_reg;
	logic [LEN_W-1:0] left_reg;
	logic nack_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	eeprom_read_pkg::host_state_e state_reg;
	eeprom_read_pkg::host_step_e  step_reg;

	// byte sent at each step of the read sequence
	function automatic logic [7:0] byte_for(input eeprom_read_pkg::host_step_e s,
		input logic [2:0] sel, input logic [12:0] a);
		unique case (s)
			eeprom_read_pkg::S_CTRL_W:  byte_for = {`CTRL_CODE, sel, `DIR_WRITE};
			eeprom_read_pkg::S_ADDR_HI: byte_for = {3'h0, a[12:8]};
			eeprom_read_pkg::S_ADDR_LO: byte_for = a[7:0];
			eeprom_read_pkg::S_CTRL_R:  byte_for = {`CTRL_CODE, sel, `DIR_READ};
			default:                    byte_for = 8'h00;
		endcase
	endfunction

	pin_sync #(.WIDTH(1)) u_sda_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.pin_in  (bus.sda_i),
		.level   (sda_lvl),
		.rise    (),
		.fall    ()
	);

	// quarter-bit enable; the bus clock is made from it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= '0;
		end else if ((state_reg == eeprom_read_pkg::H_IDLE) || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	assign tick = (div_reg == 8'(QUARTER - 1));

	// sequencer: each bit is four quarters (data, rise, sample, fall)
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= eeprom_read_pkg::H_IDLE;
			step_reg <= eeprom_read_pkg::S_CTRL_W;
			q_reg <= '0;
			bit_reg <= '0;
			tx_reg <= '0;
			rx_reg <= '0;
			sel_reg <= '0;
			addr_reg <= '0;
			left_reg <= '0;
			nack_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			busy <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
			no_ack <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			if (state_reg == eeprom_read_pkg::H_IDLE) begin
				if (cmd_start) begin
					sel_reg <= cmd_dev_sel;
					addr_reg <= cmd_addr;
					left_reg <= (cmd_len == '0) ? LEN_W'(1) : cmd_len;
					step_reg <= eeprom_read_pkg::S_CTRL_W;
					state_reg <= eeprom_read_pkg::H_START;
					q_reg <= '0;
					busy <= 1'b1;
					no_ack <= 1'b0;
				end
			end else if (tick) begin
				q_reg <= q_reg + 2'h1;
				unique case (state_reg)
					eeprom_read_pkg::H_START: begin
						// also serves as the repeated start after the address
						unique case (q_reg)
							2'h0: sda_oe_reg <= 1'b0;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b1;
							2'h3: begin
								scl_oe_reg <= 1'b1;
								state_reg <= eeprom_read_pkg::H_BIT;
								bit_reg <= '0;
								tx_reg <= byte_for(step_reg, sel_reg, addr_reg);
							end
						endcase
					end
					eeprom_read_pkg::H_BIT: begin
						unique case (q_reg)
							2'h0: begin
								if (bit_reg != 4'h8) begin
									sda_oe_reg <= (step_reg != eeprom_read_pkg::S_READ) && !tx_reg[7];
								end else begin
									// ack every byte but the last one wanted
									sda_oe_reg <= (step_reg == eeprom_read_pkg::S_READ) &&
										(left_reg != LEN_W'(1));
								end
							end
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: begin
								if (bit_reg != 4'h8) begin
									rx_reg <= {rx_reg[6:0], sda_lvl};
								end else begin
									nack_reg <= sda_lvl;
								end
							end
							2'h3: begin
								scl_oe_reg <= 1'b1;
								bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
								tx_reg <= {tx_reg[6:0], 1'b0};
								if (bit_reg == 4'h8) begin
									if ((step_reg != eeprom_read_pkg::S_READ) && nack_reg) begin
										no_ack <= 1'b1;
										state_reg <= eeprom_read_pkg::H_STOP;
									end else begin
										unique case (step_reg)
											eeprom_read_pkg::S_CTRL_W: begin
												step_reg <= eeprom_read_pkg::S_ADDR_HI;
												tx_reg <= byte_for(eeprom_read_pkg::S_ADDR_HI,
													sel_reg, addr_reg);
											end
											eeprom_read_pkg::S_ADDR_HI: begin
												step_reg <= eeprom_read_pkg::S_ADDR_LO;
												tx_reg <= byte_for(eeprom_read_pkg::S_ADDR_LO,
													sel_reg, addr_reg);
											end
											eeprom_read_pkg::S_ADDR_LO: begin
												step_reg <= eeprom_read_pkg::S_CTRL_R;
												state_reg <= eeprom_read_pkg::H_START;
											end
											eeprom_read_pkg::S_CTRL_R: begin
												step_reg <= eeprom_read_pkg::S_READ;
											end
											eeprom_read_pkg::S_READ: begin
												rd_valid <= 1'b1;
												rd_data <= rx_reg;
												left_reg <= left_reg - LEN_W'(1);
												if (left_reg == LEN_W'(1)) begin
													state_reg <= eeprom_read_pkg::H_STOP;
												end
											end
										endcase
									end
								end
							end
						endcase
					end
					eeprom_read_pkg::H_STOP: begin
						unique case (q_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b0;
							2'h3: begin
								state_reg <= eeprom_read_pkg::H_IDLE;
								busy <= 1'b0;
							end
						endcase
					end
					default: state_reg <= eeprom_read_pkg::H_IDLE;
				endcase
			end
		end
	end

	// open drain: values low, enables pull the wires
	assign bus.scl_o = 1'b0;
	assign bus.sda_h_o = 1'b0;
	assign bus.scl_oe = scl_oe_reg;
	assign bus.sda_h_oe = sda_oe_reg;
endmodule

/* testbench/eeprom_read_props.sv */
// concurrent checks on the two-wire read link
`timescale 1ns/1ps
module eeprom_read_props #(
	parameter logic [2:0] SEL = 3'h5
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// controller drivers
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_h_o,
	input wire logic sda_h_oe,
	// target drivers
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	// resolved wires
	input wire logic scl_i,
	input wire logic sda_i
);
	logic       scl_q, sda_q, first_b, rd_mode, ctrl_ok, nacked, in_frame;
	logic [1:0] byte_idx;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	// wire events as the system clock sees them
	wire        rise    = scl_i && !scl_q;
	wire        at_ack  = rise && bit_cnt == 4'h8;
	wire        own     = shift[7:1] == {4'hA, SEL};
	wire        start_c = scl_i && scl_q && sda_q && !sda_i;
	wire        stop_c  = scl_i && scl_q && !sda_q && sda_i;

	// wire history and bit position; a start or stop reframes the byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
		end else begin
			scl_q   <= scl_i;
			sda_q   <= sda_i;
			if (start_c || stop_c)
				bit_cnt <= 4'h0;
			else if (rise)
				bit_cnt <= at_ack ? 4'h0 : bit_cnt + 4'h1;
			if (rise && !at_ack)
				shift <= {shift[6:0], sda_i};
		end
	end

	// frame state: direction, addressing result, byte index, refused ack
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_frame <= 1'b0;
			first_b  <= 1'b0;
			rd_mode  <= 1'b0;
			ctrl_ok  <= 1'b0;
			nacked   <= 1'b0;
			byte_idx <= 2'h0;
		end else if (start_c || stop_c) begin
			in_frame <= start_c;
			first_b  <= start_c;
			rd_mode  <= 1'b0;
			nacked   <= 1'b0;
			byte_idx <= 2'h0;
		end else if (at_ack) begin
			first_b  <= 1'b0;
			byte_idx <= (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;
			ctrl_ok  <= first_b ? own : ctrl_ok;
			rd_mode  <= first_b ? shift[0] : rd_mode;
			nacked   <= nacked || (rd_mode && !first_b && sda_i);
		end
	end

	// one clock domain, so clock and disable are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_ack_own_code: assert property (at_ack && first_b && own |-> sda_d_oe [*4])
		else $error("own control byte not acknowledged");
	a_nack_other_code: assert property (at_ack && first_b && !own |-> !sda_d_oe)
		else $error("foreign control byte acknowledged");
	a_addr_byte_ack: assert property (at_ack && !first_b && !rd_mode && ctrl_ok
		&& byte_idx inside {2'h1, 2'h2} |-> sda_d_oe)
		else $error("address byte not acknowledged");
	a_ack_slot_free: assert property (at_ack && rd_mode && !first_b |-> !sda_d_oe)
		else $error("target holds data line in controller ack slot");
	a_nack_release: assert property (nacked |-> !sda_d_oe)
		else $error("target drives after refused ack");
	a_idle_silent: assert property (!in_frame |-> !sda_d_oe)
		else $error("target drives outside a frame");
	a_stable_high: assert property (scl_i && scl_q |-> $stable(sda_d_oe))
		else $error("target data moves while clock high");
	a_change_low: assert property ($changed(sda_d_oe) |-> !scl_i && !$past(scl_i))
		else $error("target data changes too close to clock edge");
	// window covers five quarters at the slowest default divider
	a_restart_after_addr: assert property (at_ack && !first_b && !rd_mode && ctrl_ok
		&& byte_idx == 2'h2 |-> ##[1:100] start_c)
		else $error("no repeated start after the address bytes");
	a_clock_idle: assert property (!in_frame |-> !scl_oe)
		else $error("controller holds the clock low outside a frame");

	// main traffic cases
	c_read_ctrl: cover property (at_ack && first_b && shift[0] && sda_d_oe);
	c_ctrl_ack: cover property (at_ack && rd_mode && !first_b && !sda_i);
	c_ctrl_nack: cover property (at_ack && rd_mode && !first_b && sda_i);
endmodule

/* testbench/eeprom_random_sequential_read_tb.sv */
// self-checking bench joining controller and target over the two-wire link
`timescale 1ns/1ps
module eeprom_random_sequential_read_tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cmd_start = 1'b0;
	logic        mem_load_en = 1'b0;
	logic [2:0]  straps = 3'h5;
	logic [2:0]  cmd_dev_sel = 3'h0;
	logic [12:0] cmd_addr = 13'h0000;
	logic [12:0] mem_load_addr = 13'h0000;
	logic [12:0] ptr_exp = 13'h0000;
	logic [12:0] addr_pointer;
	logic [13:0] cmd_len = 14'h0000;
	logic [7:0]  mem_load_data = 8'h00;
	logic [7:0]  rd_data;
	logic [8:0]  sh = 9'h000;
	logic [8:0]  seen[$];
	logic [7:0]  got[$];
	logic        busy, rd_valid, no_ack, read_active;
	int          errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          nb = 0;
	two_wire_if  link();

	eeprom_target #(.ADDR_W(13)) u_eeprom_target (
		.clk(clk), .reset_n(reset_n), .bus(link.target),
		.chip_select_bit_high(straps[2]), .chip_select_bit_mid(straps[1]),
		.chip_select_bit_low(straps[0]), .mem_load_en(mem_load_en),
		.mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data),
		.addr_pointer(addr_pointer), .read_active(read_active));
	// quarter of 4 clocks keeps the run short while meeting the target's minimum
	eeprom_controller #(.QUARTER(4)) u_eeprom_controller (
		.clk(clk), .reset_n(reset_n), .bus(link.controller), .cmd_start(cmd_start),
		.cmd_dev_sel(cmd_dev_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .no_ack(no_ack));
	eeprom_read_props #(.SEL(3'h5)) u_props (
		.clk(clk), .reset_n(reset_n), .scl_o(link.scl_o), .scl_oe(link.scl_oe),
		.sda_h_o(link.sda_h_o), .sda_h_oe(link.sda_h_oe), .sda_d_o(link.sda_d_o),
		.sda_d_oe(link.sda_d_oe), .scl_i(link.scl_i), .sda_i(link.sda_i));

	always #20 clk = ~clk;

	// wire monitor: nine clock pulses make one byte plus its acknowledge
	always @(posedge link.scl_i) begin
		sh = {sh[7:0], link.sda_i};
		nb++;
		if (nb == 9) begin
			seen.push_back(sh);
			nb = 0;
		end
	end
	// a start reframes; the rise just before a repeated start is dropped here
	always @(negedge link.sda_i)
		if (link.scl_i)
			nb = 0;
	// read data taken mid-cycle, clear of the edge that updates it
	always @(negedge clk)
		if (rd_valid === 1'b1)
			got.push_back(rd_data);

	// hang guard, well above the roughly fifteen thousand cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	function automatic logic [7:0] pat(input logic [12:0] a);
		return a[7:0] ^ {a[12:8], 3'h5};
	endfunction

	// one read command, then wire bytes, data, pointer and status are judged
	task automatic run(input logic [2:0] s, input logic [12:0] a, input logic [13:0] n);
		logic [8:0]  ew[$];
		logic [12:0] p;
		int          k;
		int          nn;
		nn = (n == 14'h0000) ? 1 : int'(n);
		seen = {};
		got = {};
		cmd_dev_sel = s;
		cmd_addr = a;
		cmd_len = n;
		cmd_start = 1'b1;
		tick(1);
		cmd_start = 1'b0;
		tick(1);
		for (k = 0; k < 30000 && busy !== 1'b0; k++)
			tick(1);
		ew.push_back({4'hA, s, 1'b0, s != straps});
		if (s == straps) begin
			ew.push_back({3'h0, a[12:8], 1'b0});
			ew.push_back({a[7:0], 1'b0});
			ew.push_back({4'hA, s, 2'b10});
			for (k = 0; k < nn; k++) begin
				p = a + 13'(k);
				ew.push_back({pat(p), k == nn - 1});
				if (k < got.size())
					chk("read byte", got[k], pat(p));
			end
			ptr_exp = a + 13'(nn);
		end
		chk("byte count", 16'(got.size()), 16'((s == straps) ? nn : 0));
		chk("wire count", 16'(seen.size()), 16'(ew.size()));
		for (k = 0; k < ew.size() && k < seen.size(); k++)
			chk("wire byte", seen[k], ew[k]);
		chk("pointer", addr_pointer, ptr_exp);
		chk("no_ack", no_ack, s != straps);
		chk("read_active idle", read_active, 1'b0);
	endtask

	task automatic t_random;
		run(straps, 13'h0123, 14'h0000);
		run(straps, 13'h1ABC, 14'h0001);
	endtask

	task automatic t_sequential;
		run(straps, 13'h0A55, 14'h0006);
	endtask

	task automatic t_wrap;
		run(straps, 13'h1FFD, 14'h0005);
	endtask

	task automatic t_wrong_sel;
		int s;
		for (s = 0; s < 8; s++)
			if (3'(s) != straps)
				run(3'(s), 13'h0777, 14'h0002);
	endtask

	// reset in the middle of a data byte must free the wires at once
	task automatic t_reset_mid;
		cmd_dev_sel = straps;
		cmd_addr = 13'h0400;
		cmd_len = 14'h0003;
		cmd_start = 1'b1;
		tick(1);
		cmd_start = 1'b0;
		tick(700);
		chk("read_active busy", read_active, 1'b1);
		reset_n = 1'b0;
		tick(2);
		chk("scl free", link.scl_i, 1'b1);
		chk("sda free", link.sda_i, 1'b1);
		chk("busy cleared", busy, 1'b0);
		chk("pointer cleared", addr_pointer, 13'h0000);
		reset_n = 1'b1;
		ptr_exp = 13'h0000;
		tick(4);
		run(straps, 13'h0400, 14'h0002);
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		tick(5);
		reset_n = 1'b1;
		mem_load_en = 1'b1;
		for (int a = 0; a < 8192; a++) begin
			mem_load_addr = 13'(a);
			mem_load_data = pat(13'(a));
			tick(1);
		end
		mem_load_en = 1'b0;
		tick(4);
		t_random();
		t_sequential();
		t_wrap();
		t_wrong_sel();
		t_reset_mid();
		end_of_test();
	end
endmodule
